// ### verilog/ppei_top.sv
// Port pin edge interrupt: AXI4-Lite registers, edge flags, pull selects.
// Assumes pins driven by external logic; single clock CLK_SYS, reset RST.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module ppei_top #(
  parameter int PINS = ppei_pkg::PPEI_PINS
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [PINS-1:0] PIN_IN,
  output logic [PINS-1:0] PULL_UP_EN,
  output logic [PINS-1:0] PULL_DOWN_EN,
  output logic IRQ,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [PINS-1:0] pin_edge_pull_select_bits;
  logic [PINS-1:0] pin_irq_enable_bits;
  logic [PINS-1:0] edge_flag;
  logic [PINS-1:0] pull_enable;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] edge_hit;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic w_held;
  logic [31:0] next_rdata;

  ppei_edge_detect #(.WIDTH(PINS)) u_edge (
    .clk(CLK_SYS),
    .rst(RST),
    .pin_async(PIN_IN),
    .polarity(pin_edge_pull_select_bits),
    .pin_sync(pin_sync),
    .edge_hit(edge_hit)
  );

  // Write channel: address and data latched independently, in any order
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_go = aw_held & w_held;
  wire b_done = S_AXI_BVALID & S_AXI_BREADY;
  logic [3:0] w_strb;

  // Low address bits are dropped, so any byte address maps to its word
  function automatic logic [11:0] word_addr(input logic [11:0] addr);
    return {addr[11:2], 2'b00};
  endfunction

  // Shared map decode; pin state answers reads only, a write to it is an error
  function automatic logic reg_mapped(input logic [11:0] addr, input logic for_read);
    logic hit;
    hit = (addr == ppei_pkg::PPEI_OFS_POLARITY)
        | (addr == ppei_pkg::PPEI_OFS_ENABLE)
        | (addr == ppei_pkg::PPEI_OFS_FLAG)
        | (addr == ppei_pkg::PPEI_OFS_PULL_EN);
    if (for_read) begin
      hit = hit | (addr == ppei_pkg::PPEI_OFS_PIN_STATE);
    end
    return hit;
  endfunction

  // Only byte lane 0 holds register bits; a write without it changes nothing
  wire wr_en = wr_go & w_strb[0];
  wire wr_pol = wr_en & (aw_addr == ppei_pkg::PPEI_OFS_POLARITY);
  // R5 writable any time
  wire wr_ena = wr_en & (aw_addr == ppei_pkg::PPEI_OFS_ENABLE);
  wire wr_flg = wr_en & (aw_addr == ppei_pkg::PPEI_OFS_FLAG);
  wire wr_pul = wr_en & (aw_addr == ppei_pkg::PPEI_OFS_PULL_EN);
  wire wr_hit = reg_mapped(aw_addr, 1'b0);
  wire [1:0] next_bresp = wr_hit ? ppei_pkg::PPEI_RESP_OKAY : ppei_pkg::PPEI_RESP_SLVERR;
  wire [PINS-1:0] w_byte = w_data[PINS-1:0];

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= word_addr(S_AXI_AWADDR);
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  // The answer stands until taken, so a slow master loses no response
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= ppei_pkg::PPEI_RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= next_bresp;
    end else if (b_done) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // R4 one bit per pin
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_edge_pull_select_bits <= PINS'(ppei_pkg::PPEI_RST_POLARITY);
    end else if (wr_pol) begin
      pin_edge_pull_select_bits <= w_byte;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_irq_enable_bits <= PINS'(ppei_pkg::PPEI_RST_ENABLE);
    end else if (wr_ena) begin
      pin_irq_enable_bits <= w_byte;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pull_enable <= PINS'(ppei_pkg::PPEI_RST_PULL_EN);
    end else if (wr_pul) begin
      pull_enable <= w_byte;
    end
  end

  // Sticky flags: a new edge wins over a write-one-to-clear in the same cycle
  // Flags set on any selected edge; the enable only masks the request
  localparam logic [PINS-1:0] FLAG_RESET = PINS'(ppei_pkg::PPEI_RST_FLAG);
  wire [PINS-1:0] flag_clr = wr_flg ? w_byte : '0;
  wire [PINS-1:0] next_flag = (edge_flag & ~flag_clr) | edge_hit;
  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_flag
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          edge_flag[p] <= FLAG_RESET[p];
        end else begin
          edge_flag[p] <= next_flag[p];
        end
      end
    end
  endgenerate

  // R3 flag masked
  wire [PINS-1:0] armed = edge_flag & pin_irq_enable_bits;
  // R6 OR over pins
  assign IRQ = |armed;

  // R2 pull direction
  // One select bit picks the side, so both pulls can never be on together
  generate
    for (p = 0; p < PINS; p++) begin : g_pull
      assign PULL_DOWN_EN[p] = pull_enable[p] & pin_edge_pull_select_bits[p];
      assign PULL_UP_EN[p] = pull_enable[p] & ~pin_edge_pull_select_bits[p];
    end
  endgenerate

  // Read channel: one read at a time, answer one cycle after address
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire r_done = S_AXI_RVALID & S_AXI_RREADY;
  wire [11:0] ar = word_addr(S_AXI_ARADDR);
  wire rd_hit = reg_mapped(ar, 1'b1);
  wire [1:0] next_rresp = rd_hit ? ppei_pkg::PPEI_RESP_OKAY : ppei_pkg::PPEI_RESP_SLVERR;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (ar)
      ppei_pkg::PPEI_OFS_POLARITY: next_rdata[PINS-1:0] = pin_edge_pull_select_bits;
      ppei_pkg::PPEI_OFS_ENABLE: next_rdata[PINS-1:0] = pin_irq_enable_bits;
      ppei_pkg::PPEI_OFS_FLAG: next_rdata[PINS-1:0] = edge_flag;
      ppei_pkg::PPEI_OFS_PULL_EN: next_rdata[PINS-1:0] = pull_enable;
      ppei_pkg::PPEI_OFS_PIN_STATE: next_rdata[PINS-1:0] = pin_sync;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Data is captured with the address, so it stands unchanged until taken
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= ppei_pkg::PPEI_RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
    end else if (r_done) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule // ppei_top
`default_nettype wire

// ### verilog/ppei_pkg.sv
// Constants and register map of the port pin edge interrupt block.
// Assumes an AXI4-Lite master on the system clock and 32-bit data.
// What this block does
// R1 - Rising edge detected when polarity bit is 1, falling edge when 0.
// R2 - Enabled pull is pull-down for polarity 1, pull-up for polarity 0.
// R3 - Enable bit 1 arms the pin interrupt; 0 masks its flag.
// R4 - One polarity bit and one enable bit per pin, bits 7 to 0.
// R5 - Interrupt enable register is readable and writable at any time.
// R6 - Request is OR over pins of flag AND enable.
`default_nettype none
package ppei_pkg;
  localparam int PPEI_PINS = 8;
  localparam logic [11:0] PPEI_OFS_POLARITY = 12'h000;
  localparam logic [11:0] PPEI_OFS_ENABLE = 12'h004;
  localparam logic [11:0] PPEI_OFS_FLAG = 12'h008;
  localparam logic [11:0] PPEI_OFS_PULL_EN = 12'h00C;
  localparam logic [11:0] PPEI_OFS_PIN_STATE = 12'h010;
  localparam logic [7:0] PPEI_RST_POLARITY = 8'h00;
  localparam logic [7:0] PPEI_RST_ENABLE = 8'h00;
  localparam logic [7:0] PPEI_RST_FLAG = 8'h00;
  localparam logic [7:0] PPEI_RST_PULL_EN = 8'h00;
  localparam logic [1:0] PPEI_RESP_OKAY = 2'b00;
  localparam logic [1:0] PPEI_RESP_SLVERR = 2'b10;
endpackage : ppei_pkg
`default_nettype wire

// ### verilog/ppei_edge_detect.sv
// Per-pin synchroniser and polarity-selected edge detector.
// Assumes pins are asynchronous to CLK_SYS.
`default_nettype none
module ppei_edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_async,
  input wire logic [WIDTH-1:0] polarity,
  output logic [WIDTH-1:0] pin_sync,
  output logic [WIDTH-1:0] edge_hit
);
  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] sync_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_prev <= '0;
    end else begin
      sync_a <= pin_async;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign pin_sync = sync_b;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // R1 rising or falling
      assign edge_hit[i] = polarity[i] ? (sync_b[i] & ~sync_prev[i])
                                       : (~sync_b[i] & sync_prev[i]);
    end
  endgenerate
endmodule // ppei_edge_detect
`default_nettype wire

// ### sim/ppei_chk_sva.sv
// Port-level checker for the pin edge interrupt block.
// Assumes it is bound into ppei_top and sees only its ports.
`default_nettype none
module ppei_chk #(parameter int PINS = 8) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [PINS-1:0] PIN_IN,
  input wire logic [PINS-1:0] PULL_UP_EN,
  input wire logic [PINS-1:0] PULL_DOWN_EN,
  input wire logic IRQ,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_pull_excl: assert property ((PULL_UP_EN & PULL_DOWN_EN) == '0)
    else $error("pull-up and pull-down on together");
  // Pin edges take three clock edges to reach the request
  a_irq_cause: assert property ($changed(IRQ) |-> $rose(S_AXI_BVALID)
    || $past(PIN_IN, 2) != $past(PIN_IN, 5)) else $error("request moved without cause");
  a_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
    && S_AXI_WREADY |=> ##1 S_AXI_BVALID) else $error("write answer late");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  a_aw_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write taken while answer pending");
endmodule // ppei_chk
bind ppei_top ppei_chk #(.PINS(PINS)) i_ppei_chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .PIN_IN(PIN_IN), .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .IRQ(IRQ),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));
`default_nettype wire

// ### sim/ppei_pin_drv.sv
// Model of the external signals at the eight port pins.
// Assumes the bench picks per pin whether it drives or floats.
`default_nettype none
module ppei_pin_drv (
  input wire logic clk,
  input wire logic [7:0] drive_en,
  input wire logic [7:0] drive_val,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_down,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // floating pin follows pull
  // With no pull it toggles, so a stale level never passes for a held one
  always @(posedge clk) begin
    pin <= (drive_en & drive_val) | (~drive_en & (pull_up | (~pull_down & ~pin)));
  end
endmodule // ppei_pin_drv
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the pin edge interrupt block.
// Assumes ppei_top with eight pins and the pin model at its port.
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic c, rst, awv, wv, arv, awrdy, wrdy, bv, arrdy, rv, ie;
  logic [11:0] aw, ar;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [3:0] ws;
  logic [7:0] pin, pu, pd, de, dv, pol, en, flg, cur;
  int n_fail, num_checks;
  ppei_top i_ppei_top (.CLK_SYS(c), .RST(rst), .PIN_IN(pin), .PULL_UP_EN(pu),
    .PULL_DOWN_EN(pd), .IRQ(ie), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1));
  ppei_pin_drv i_ppei_pin_drv (.clk(c), .drive_en(de), .drive_val(dv), .pull_up(pu),
    .pull_down(pd), .pin(pin));
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge c);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    `CHK(br, e)
  endtask
  task automatic bus_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    ar <= a;
    arv <= 1'b1;
    do begin
      @(posedge c);
      if (arv && arrdy) arv <= 1'b0;
    end while (!rv);
    `CHK(rd, d)
    `CHK(rr, e)
  endtask
  // Drive or float the pins, then compare flags, request and pin state
  task automatic step(input logic [7:0] m, input logic [7:0] v);
    de <= m;
    dv <= v;
    repeat (6) @(posedge c);
    flg = flg | (pol & ~cur & v) | (~pol & cur & ~v);
    cur = v;
    `CHK(ie, |(flg & en))
    bus_rd(12'h008, 32'(flg), 2'b00);
    bus_rd(12'h010, 32'(cur), 2'b00);
  endtask
  initial begin
    c = 1'b0;
    forever #4 c = ~c;
  end
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  initial begin
    {awv, wv, arv, aw, ar, wd, dv, pol, en, flg, cur} = '0;
    {rst, de} = 9'h1FF;
    ws = 4'hF;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(32'h2210));
    repeat (4) @(posedge c);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) bus_rd(12'(4 * i), 32'h0, 2'b00);
    bus_rd(12'h100, 32'h0, 2'b10);
    bus_wr(12'h100, 32'hFF, 2'b10);
    for (int k = 0; k < 12; k++) begin
      pol = 8'($urandom);
      en = 8'($urandom);
      bus_wr(12'h000, 32'(pol), 2'b00);
      bus_wr(12'h004, 32'(en), 2'b00);
      bus_rd(12'h004, 32'(en), 2'b00);
      bus_rd(12'h000, 32'(pol), 2'b00);
      step(8'hFF, 8'($urandom));
      step(8'hFF, ~cur);
      if (k % 3 == 0) begin
        bus_wr(12'h00C, 32'hFF, 2'b00);
        `CHK({pu, pd}, {~pol, pol})
        step(8'h00, ~pol);
        step(8'hFF, cur);
        bus_wr(12'h00C, 32'h0, 2'b00);
        `CHK({pu, pd}, 16'h0000)
      end
      bus_wr(12'h008, 32'(flg), 2'b00);
      flg = 8'h00;
      `CHK(ie, 1'b0)
    end
    // A write without lane 0 is answered but changes nothing
    ws <= 4'hE;
    bus_wr(12'h004, 32'(~en), 2'b00);
    ws <= 4'hF;
    bus_rd(12'h004, 32'(en), 2'b00);
    bus_wr(12'h010, 32'hFF, 2'b10);
    bus_rd(12'h010, 32'(cur), 2'b00);
    summarize;
  end
endmodule // tb
`default_nettype wire
